// ### epg_consts.svh
`ifndef EPG_CONSTS_SVH
`define EPG_CONSTS_SVH
// opcodes (8-bit serial instructions)
`define EPG_WRITE_ENABLE_INSTRUCTION 8'h06
`define EPG_WRITE_DISABLE_INSTRUCTION 8'h04
`define EPG_READ_STATUS_INSTRUCTION 8'h05
`define EPG_OP_WRSR_CODE 8'h01
`define EPG_OP_READ_CODE 8'h03
`define EPG_OP_WRITE_CODE 8'h02
// bit counts for a complete instruction
`define EPG_OPC_BITS 8
`define EPG_ADDR_BITS 16
`define EPG_BYTE_BITS 8
// status register bit positions
`define EPG_ST_BUSY_POS 0
`define EPG_ST_WRITE_ENABLE_LATCH_POS 1
// synchroniser reset: supply low, select high, clock and data low
`define EPG_SYNC_RST_VAL 4'h4
// internal write cycle time
`define EPG_TWC_NS 5000000
`define EPG_CLK_NS 10
`define EPG_TWC_CYC ((`EPG_TWC_NS + `EPG_CLK_NS - 1) / `EPG_CLK_NS)
`endif

// ### epg_pkg.sv
`default_nettype none
package epg_pkg;
  typedef enum logic [3:0] {
    EPG_OFF = 4'b0001,
    EPG_STBY = 4'b0010,
    EPG_READY = 4'b0100,
    EPG_BUSY = 4'b1000
  } epg_state_t;
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } epg_spi_in_t;
  typedef struct packed {
    logic so;
    logic so_oe;
  } epg_spi_out_t;
endpackage
`default_nettype wire

// ### epg_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser, one per bit
module epg_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clock_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic [WIDTH-1:0] d_i, // async inputs
  input wire logic [WIDTH-1:0] rst_val_i, // value held in reset
  output logic [WIDTH-1:0] q_o // synchronised
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } epg_sync_st_t;
  epg_sync_st_t st_reg;
  epg_sync_st_t st_next;
  initial begin
    if (WIDTH < 1) $error("epg_sync: WIDTH must be at least 1");
  end
  // first stage feeds only the second
  always_comb begin
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end
  // reset value comes through the clocked path, not an async load
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_reg.s1 <= rst_val_i;
      st_reg.s2 <= rst_val_i;
    end else begin
      st_reg <= st_next;
    end
  end
  assign q_o = st_reg.s2;
endmodule // epg_sync
`default_nettype wire

// ### epg_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "epg_consts.svh"
// ---------------------------------------------------------------------
// Overview of operation
// (RULE1) Supply good after being low moves the device from reset to standby.
// (RULE2) Supply loss puts the device back into reset, clearing the write enable latch and the output enable.
// (RULE3) Leaving reset, the write enable latch is clear and the device idles.
// (RULE4) The host must send write enable before any write, else it is dropped.
// (RULE5) Instructions are accepted only after chip select is seen low.
// (RULE6) A completed write clears the write enable latch.
// (RULE7) The internal write starts on the chip select rise after a full frame.
// (RULE8) Array access during an internal write is ignored.
// (RULE9) Unknown opcodes do nothing and leave the output undriven.
// (RULE10) During a write only the status read is honoured.
// (RULE11) Write enable sets the latch, write disable clears it.
// (RULE12) Busy reads one during the internal write and zero when ready.
// (RULE13) A write cut short before a full data byte starts no write.
// ---------------------------------------------------------------------
module epg_gate
  import epg_pkg::*;
#(
  parameter int TWC_CYC = `EPG_TWC_CYC
) (
  input wire logic clock_i, // 100 MHz
  input wire logic rst_i, // sync reset, active high
  input wire logic supply_ok_i, // supply above trigger level
  input wire epg_spi_in_t spi_i, // chip select, clock, data in
  output epg_spi_out_t spi_o, // data out and its enable
  output logic write_start_o, // pulse: internal write begins
  output logic wr_status_o, // pulse qualifier: write is to status
  output logic busy_o, // internal write running
  output logic write_enable_latch_o, // write enable latch
  output epg_state_t state_o // power/command state
);
  initial begin
    if (TWC_CYC < 1) $error("epg_gate: TWC_CYC must be at least 1");
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [3:0] sync_q;
  epg_sync #(.WIDTH(4)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .d_i({supply_ok_i, spi_i.cs_n, spi_i.sck, spi_i.si}),
    .rst_val_i(`EPG_SYNC_RST_VAL),
    .q_o(sync_q)
  );
  logic pwr_ok, cs_n, sck, si;
  assign {pwr_ok, cs_n, sck, si} = sync_q;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    epg_state_t state;
    logic cs_n_d;
    logic sck_d;
    logic write_enable_latch;
    logic [7:0] opc;
    logic [5:0] bits;
    logic done;
    logic [7:0] sh_out;
    logic so;
    logic so_oe;
    logic [31:0] cnt;
    logic start;
    logic wr_st;
  } epg_st_t;
  epg_st_t st_reg;
  epg_st_t st_next;

  logic sck_rise, sck_fall, cs_rise, cs_fall, frame;
  logic [7:0] opc_now;
  logic [7:0] status;
  logic opc_done, rd_ok, wr_full;

  assign sck_rise = sck & ~st_reg.sck_d;
  assign sck_fall = ~sck & st_reg.sck_d;
  assign cs_rise = cs_n & ~st_reg.cs_n_d;
  assign cs_fall = ~cs_n & st_reg.cs_n_d;
  assign frame = ~cs_n & (st_reg.state == EPG_READY ||
                          st_reg.state == EPG_BUSY);
  assign opc_now = {st_reg.opc[6:0], si};
  assign opc_done = st_reg.bits >= 6'(`EPG_OPC_BITS);
  assign status = {6'h00, st_reg.write_enable_latch,
                   st_reg.state == EPG_BUSY};
  // write data counted past opcode, address (write opcode only) and one byte
  assign wr_full = (st_reg.opc == `EPG_OP_WRITE_CODE) ?
    (st_reg.bits >= 6'(`EPG_OPC_BITS + `EPG_ADDR_BITS + `EPG_BYTE_BITS)) :
    (st_reg.bits >= 6'(`EPG_OPC_BITS + `EPG_BYTE_BITS));
  // status reads are the only instruction served while busy; the opcode
  // completing on this very rise counts too, so the enable is not dropped
  assign rd_ok = st_reg.opc == `EPG_READ_STATUS_INSTRUCTION || // RULE10
    (st_reg.bits == 6'(`EPG_OPC_BITS - 1) &&
     opc_now == `EPG_READ_STATUS_INSTRUCTION);

  // next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.cs_n_d = cs_n;
    st_next.sck_d = sck;
    st_next.start = 1'b0;
    st_next.wr_st = 1'b0;
    case (st_reg.state)
      EPG_OFF: begin
        st_next.write_enable_latch = 1'b0; // RULE3
        st_next.so_oe = 1'b0;
        if (pwr_ok) st_next.state = EPG_STBY; // RULE1
      end
      EPG_STBY: begin
        // a select already low at power-up must first go high and low
        if (cs_fall) begin
          st_next.state = EPG_READY; // RULE5
          st_next.bits = 6'h00;
          st_next.done = 1'b0;
        end
      end
      EPG_READY, EPG_BUSY: begin
        if (cs_fall) begin
          st_next.bits = 6'h00; // RULE5
          st_next.done = 1'b0;
          st_next.so_oe = 1'b0;
        end
        if (frame && sck_rise && !st_reg.done) begin
          st_next.opc = opc_done ? st_reg.opc : opc_now;
          if (st_reg.bits != 6'h3f) st_next.bits = st_reg.bits + 6'h01;
        end
        // opcode complete: start the status shift-out
        if (frame && sck_rise && st_reg.bits == 6'(`EPG_OPC_BITS - 1) &&
            opc_now == `EPG_READ_STATUS_INSTRUCTION) begin
          st_next.sh_out = status;
          st_next.so_oe = 1'b1;
        end
        if (frame && sck_fall && st_reg.so_oe) begin
          st_next.so = st_reg.sh_out[7];
          st_next.sh_out = {st_reg.sh_out[6:0], st_reg.sh_out[7]};
        end
        if (cs_rise) begin
          st_next.so_oe = 1'b0;
          st_next.done = 1'b1;
          // unknown opcodes and busy-time array access fall through
          if (st_reg.state == EPG_READY && opc_done) begin // RULE8 RULE9
            case (st_reg.opc)
              `EPG_WRITE_ENABLE_INSTRUCTION: begin
                st_next.write_enable_latch = 1'b1; // RULE11
              end
              `EPG_WRITE_DISABLE_INSTRUCTION: begin
                st_next.write_enable_latch = 1'b0; // RULE11
              end
              `EPG_OP_WRITE_CODE, `EPG_OP_WRSR_CODE: begin
                // latch gates writes; short frames are dropped
                if (st_reg.write_enable_latch && wr_full) begin // RULE4 RULE13
                  st_next.state = EPG_BUSY; // RULE7
                  st_next.cnt = 32'(TWC_CYC);
                  st_next.start = 1'b1;
                  st_next.wr_st = st_reg.opc == `EPG_OP_WRSR_CODE;
                end
              end
              default: begin
                st_next.write_enable_latch = st_reg.write_enable_latch;
              end
            endcase
          end
        end
        if (st_reg.state == EPG_BUSY) begin
          if (st_reg.cnt <= 32'h1) begin
            st_next.state = EPG_READY; // RULE12
            st_next.write_enable_latch = 1'b0; // RULE6
          end else begin
            st_next.cnt = st_reg.cnt - 32'h1;
          end
        end
        if (!rd_ok && st_reg.state == EPG_BUSY) st_next.so_oe = 1'b0;
      end
      default: st_next.state = EPG_OFF;
    endcase
    if (!pwr_ok) begin
      st_next.state = EPG_OFF; // RULE2
      st_next.write_enable_latch = 1'b0;
      st_next.so_oe = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.state <= EPG_OFF;
      st_reg.cs_n_d <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign spi_o.so = st_reg.so;
  assign spi_o.so_oe = st_reg.so_oe; // RULE9
  assign write_start_o = st_reg.start;
  assign wr_status_o = st_reg.wr_st;
  assign busy_o = st_reg.state == EPG_BUSY; // RULE12
  assign write_enable_latch_o = st_reg.write_enable_latch;
  assign state_o = st_reg.state;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_write_go;
    write_start_o ##0 busy_o;
  endsequence
  AST_START_BUSY: assert property ( // RULE7
    @(posedge clock_i) disable iff (rst_i)
    write_start_o |-> busy_o) else $error("start without busy");
  AST_START_LATCH: assert property ( // RULE4
    @(posedge clock_i) disable iff (rst_i)
    $rose(busy_o) |-> $past(write_enable_latch_o))
    else $error("write without latch");
  AST_DONE_CLR: assert property ( // RULE6
    @(posedge clock_i) disable iff (rst_i)
    $fell(busy_o) && pwr_ok |-> !write_enable_latch_o)
    else $error("latch kept");
  AST_PWR_OFF: assert property ( // RULE2
    @(posedge clock_i) disable iff (rst_i)
    !pwr_ok |=> state_o == EPG_OFF && !write_enable_latch_o)
    else $error("no reset");
  AST_OFF_STBY: assert property ( // RULE1
    @(posedge clock_i) disable iff (rst_i)
    state_o == EPG_OFF && pwr_ok |=> state_o == EPG_STBY)
    else $error("no standby");
  AST_STBY_LATCH: assert property ( // RULE3
    @(posedge clock_i) disable iff (rst_i)
    state_o == EPG_STBY |-> !write_enable_latch_o)
    else $error("latch set at power-up");
  AST_STBY_QUIET: assert property ( // RULE5
    @(posedge clock_i) disable iff (rst_i)
    state_o == EPG_STBY |-> !spi_o.so_oe) else $error("output in standby");
  // a supply loss may legally end the write, so it cancels the check
  AST_BUSY_HOLD: assert property ( // RULE8
    @(posedge clock_i) disable iff (rst_i || !pwr_ok)
    s_write_go |=> busy_o [*8]) else $error("write cut short");
  AST_BUSY_LATCH: assert property ( // RULE10
    @(posedge clock_i) disable iff (rst_i)
    busy_o && $past(busy_o) && pwr_ok |-> $stable(write_enable_latch_o))
    else $error("latch changed while busy");
  AST_OE_STATUS: assert property ( // RULE9
    @(posedge clock_i) disable iff (rst_i)
    $rose(spi_o.so_oe) |-> st_reg.opc == `EPG_READ_STATUS_INSTRUCTION)
    else $error("output for other opcode");
endmodule // epg_gate
`default_nettype wire

// ### epg_host.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// host controller: sends frames msb first, 125 ns link clock
// ------------------------------------------------------------
module epg_host
  import epg_pkg::*;
(
  input wire epg_spi_out_t dev_i, // device data out
  output epg_spi_in_t host_o // select, clock, data
);
  logic [7:0] rx;
  // idle: deselected, clock parked low
  initial host_o = 3'b100;
  // clock stands still between frames, so no stray edges
  task automatic frame(input logic [39:0] bits, input int n);
    host_o.cs_n = 1'b0;
    #125;
    for (int i = n - 1; i >= 0; i--) begin
      host_o.si = bits[i];
      #62.5 host_o.sck = 1'b1;
      // an undriven line reads as the inverse of the last level
      rx = {rx[6:0], dev_i.so_oe ? dev_i.so : ~dev_i.so};
      #62.5 host_o.sck = 1'b0;
    end
    #125 host_o.cs_n = 1'b1;
    host_o.si = ~host_o.si; // released line, no stale level
    #250;
  endtask
endmodule // epg_host
`default_nettype wire

// ### tb_eeprom_powerup_command_gate.sv
`timescale 1ns/1ps
`default_nettype none
module tb_eeprom_powerup_command_gate;
  import epg_pkg::*;
  logic clock_i = 0, rst_i, supply_ok_i;
  epg_spi_in_t host_out;
  epg_spi_out_t dev_out;
  logic write_start_o, wr_status_o, busy_o, write_enable_latch_o;
  epg_state_t state_o;
  int failures, cmp_count, seed, cyc, starts, st_starts;
  logic oe_seen;
  logic [7:0] d, op;
  // ------------------------------------------------------------
  // clock, design and host
  // ------------------------------------------------------------
  always #5 clock_i = ~clock_i;
  epg_gate #(.TWC_CYC(1000)) uut (.clock_i(clock_i), .rst_i(rst_i),
    .supply_ok_i(supply_ok_i), .spi_i(host_out), .spi_o(dev_out),
    .write_start_o(write_start_o), .wr_status_o(wr_status_o),
    .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o),
    .state_o(state_o));
  epg_host host (.dev_i(dev_out), .host_o(host_out));
  // pulse counters and watchdog; a hang ends as a failure
  always @(posedge clock_i) begin
    cyc++;
    if (write_start_o === 1'b1) starts++;
    if (write_start_o === 1'b1 && wr_status_o === 1'b1) st_starts++;
    if (dev_out.so_oe === 1'b1) oe_seen = 1'b1;
    if (cyc == 30000) begin
      failures++;
      wrap_up;
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] status_exp(logic latch, logic busy);
    return {6'h0, latch, busy};
  endfunction
  function automatic bit known(logic [7:0] c);
    return c inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h02};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait for the internal write to finish
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    #1;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 30650;
    rst_i = 1'b1;
    supply_ok_i = 1'b0;
    {failures, cmp_count, cyc, starts, st_starts} = '0;
    oe_seen = 1'b0;
    repeat (3) @(posedge clock_i);
    #1 rst_i = 1'b0;
    repeat (5) @(posedge clock_i);
    #1 check(8'(state_o), 8'(EPG_OFF));
    supply_ok_i = 1'b1;
    repeat (6) @(posedge clock_i);
    #1 check(8'(state_o), 8'(EPG_STBY));
    check(8'(write_enable_latch_o), 8'h00);
    host.frame(40'h06, 8);
    check(8'(write_enable_latch_o), 8'h01);
    host.frame(40'h04, 8);
    check(8'(write_enable_latch_o), 8'h00);
    d = 8'($random(seed));
    host.frame({8'h02, 16'h0010, d}, 32);
    check(8'(starts), 8'h00);
    $display("test enable latch done");
    // cut-short write, then an unknown opcode
    host.frame(40'h06, 8);
    host.frame({8'h02, 16'h0020}, 24);
    check(8'(starts), 8'h00);
    do op = 8'($random(seed)); while (known(op));
    host.frame({32'h0, op}, 8);
    check(8'(oe_seen), 8'h00);
    check(8'(write_enable_latch_o), 8'h01);
    $display("test refusals done");
    // full write, commands during the internal cycle
    d = 8'($random(seed));
    host.frame({8'h02, 16'h0030, d}, 32);
    check(8'(starts), 8'h01);
    check(8'(busy_o), 8'h01);
    host.frame(40'h04, 8);
    check(8'(write_enable_latch_o), 8'h01);
    host.frame({8'h02, 16'h0040, d}, 32);
    check(8'(starts), 8'h01);
    host.frame({24'h0, 8'h05, 8'h00}, 16);
    check(host.rx, status_exp(1'b1, 1'b1));
    wait_idle;
    check(8'(write_enable_latch_o), 8'h00);
    host.frame({24'h0, 8'h05, 8'h00}, 16);
    check(host.rx, status_exp(1'b0, 1'b0));
    $display("test write cycle done");
    // status write, then brown-out
    host.frame(40'h06, 8);
    host.frame({24'h0, 8'h01, 8'($random(seed))}, 16);
    check(8'(st_starts), 8'h01);
    wait_idle;
    check(8'(write_enable_latch_o), 8'h00);
    host.frame(40'h06, 8);
    @(posedge clock_i);
    #1 supply_ok_i = 1'b0;
    repeat (6) @(posedge clock_i);
    #1 check(8'(state_o), 8'(EPG_OFF));
    check(8'(write_enable_latch_o), 8'h00);
    supply_ok_i = 1'b1;
    repeat (6) @(posedge clock_i);
    #1 check(8'(state_o), 8'(EPG_STBY));
    $display("test power cycle done");
    wrap_up;
  end
endmodule // tb_eeprom_powerup_command_gate
`default_nettype wire
